// ### codec_cfg_pkg.sv
package codec_cfg_pkg;
  // Command word fields
  localparam int unsigned CMD_RW_BIT = 13;
  localparam int unsigned CMD_ADDR_MSB = 12;
  localparam int unsigned CMD_ADDR_LSB = 8;
  localparam int unsigned CMD_WORD_BITS = 16;

  // Register addresses
  localparam logic [4:0] ADDR_ANALOG_INPUT_CONFIG = 5'h05;
  localparam logic [4:0] ADDR_DIGITAL_CONTROL_CONFIG = 5'h06;
  localparam logic [4:0] ADDR_FRAME_SYNC_DELAY_COUNT = 5'h07;
  localparam logic [4:0] ADDR_FRAME_SYNC_TOTAL_COUNT = 5'h08;

  // Analog configuration fields
  localparam int unsigned ANA_HPF_BYPASS_BIT = 2;
  localparam int unsigned ANA_SEL_MSB = 1;
  localparam int unsigned ANA_SEL_LSB = 0;

  // Digital configuration fields
  localparam int unsigned DIG_FREE_RUN_BIT = 5;
  localparam int unsigned DIG_FSD_DISABLE_BIT = 4;
  localparam int unsigned DIG_SIXTEEN_BIT = 3;
  localparam int unsigned DIG_FORCE_SEC_BIT = 2;
  localparam int unsigned DIG_SOFT_RESET_BIT = 1;
  localparam int unsigned DIG_SOFT_PDN_BIT = 0;
  localparam logic [7:0] DIG_WRITE_MASK = 8'h3f;

  // Input select codes
  typedef enum logic [1:0] {
    SEL_LOOPBACK = 2'b00,
    SEL_PRIMARY = 2'b01,
    SEL_AUX = 2'b10,
    SEL_SUMMING = 2'b11
  } input_sel_t;

  // Values after power-up or reset
  localparam logic [3:0] ANALOG_RESET = 4'h1;
  localparam logic [7:0] DIGITAL_RESET = 8'h00;
  localparam logic [7:0] FS_DELAY_RESET = 8'h00;
  localparam logic [7:0] FS_COUNT_RESET = 8'h01;

  // Shift clocks between consecutive frame syncs of one cycle
  localparam logic [7:0] FS_SPACING = 8'h40;
  localparam logic [3:0] LAST_BIT = 4'hf;
endpackage : codec_cfg_pkg

// ### cdc_sync.sv
`timescale 1ns/1ns
module cdc_sync #(
  parameter int unsigned W = 1
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  typedef struct packed {
    logic [W-1:0] first;
    logic [W-1:0] second;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  // First stage feeds the second only
  always_comb begin
    st_nxt.first = i_d;
    st_nxt.second = st_r.first;
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_q = st_r.second;
endmodule : cdc_sync

// ### codec_config_regs_five_to_eight.sv
// Functional notes
// - Address 00101 targets analog config, low four bits
// - Analog bit 2 set bypasses high-pass filter
// - Input select: loopback, primary, aux, summing
// - Analog config resets to 0001
// - Analog read duplicates low nibble into high
// - Address 00110 targets digital config, bits 5:0
// - Digital bit 5 enables free-run conversion
// - Digital bit 3 selects 16-bit mode
// - Digital bit 2 forces secondary after primary
// - Digital bit 1 software reset, self-clearing
// - Digital bit 0 software power-down, else pin
// - Digital config resets to zero
// - Address 00111 loads frame-sync delay in shift clocks
// - Address 01000 loads frame-sync count
// - Generate count frame syncs per cycle
// - Frame-sync count resets to one
// - Bit 13 read/write; read byte in low byte
`timescale 1ns/1ns
module codec_config_regs_five_to_eight (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_sclk,
  input wire logic i_sec_frame,
  input wire logic i_din,
  input wire logic i_frame_start,
  input wire logic i_power_down_pin,
  output logic o_dout,
  output logic o_frame_sync_pulse,
  output logic o_delayed_frame_sync,
  output logic o_hpf_bypass,
  output codec_cfg_pkg::input_sel_t o_input_sel,
  output logic o_free_run,
  output logic o_sixteen_bit_mode,
  output logic o_force_secondary,
  output logic o_soft_reset,
  output logic o_power_down
);
  import codec_cfg_pkg::*;

  typedef struct packed {
    logic [3:0] analog;
    logic [7:0] digital;
    logic [7:0] fs_delay;
    logic [7:0] fs_count;
    logic [7:0] rd_byte;
    logic seen_toggle;
    logic soft_reset;
    logic power_down;
  } core_state_t;

  typedef struct packed {
    logic [3:0] bit_cnt;
    logic [14:0] in_shift;
    logic [15:0] word;
    logic toggle;
    logic [15:0] out_shift;
    logic dout;
    logic [7:0] fs_left;
    logic [7:0] gap;
    logic [7:0] dly;
    logic fs_pulse;
    logic fsd_pulse;
  } link_state_t;

  core_state_t core_r;
  core_state_t core_nxt;
  link_state_t link_r;
  link_state_t link_nxt;

  logic toggle_core;
  logic pdn_pin_core;
  logic [24:0] cfg_to_link;
  logic [24:0] cfg_link;
  logic [7:0] link_rd_byte;
  logic [7:0] link_fs_delay;
  logic [7:0] link_fs_count;
  logic link_fsd_disable;

  // Link to core: bundled word, qualified by a synchronised toggle
  cdc_sync #(.W(1)) u_toggle_sync (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_d(link_r.toggle),
    .o_q(toggle_core)
  );

  cdc_sync #(.W(1)) u_pin_sync (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_d(i_power_down_pin),
    .o_q(pdn_pin_core)
  );

  // Core to link: quasi-static config and read byte
  assign cfg_to_link = {core_r.digital[DIG_FSD_DISABLE_BIT], core_r.fs_count,
                        core_r.fs_delay, core_r.rd_byte};

  cdc_sync #(.W(25)) u_cfg_sync (
    .i_clk(i_sclk),
    .i_reset_n(i_reset_n),
    .i_d(cfg_to_link),
    .o_q(cfg_link)
  );

  assign link_rd_byte = cfg_link[7:0];
  assign link_fs_delay = cfg_link[15:8];
  assign link_fs_count = cfg_link[23:16];
  assign link_fsd_disable = cfg_link[24];

  // Core domain: command decode and register bank
  always_comb begin
    logic [4:0] addr;
    logic [7:0] data;
    logic is_read;
    logic new_word;
    addr = link_r.word[CMD_ADDR_MSB:CMD_ADDR_LSB];
    data = link_r.word[7:0];
    is_read = link_r.word[CMD_RW_BIT];
    new_word = toggle_core != core_r.seen_toggle;

    core_nxt = core_r;
    core_nxt.seen_toggle = toggle_core;
    core_nxt.soft_reset = 1'b0;
    if (new_word) begin
      if (is_read) begin
        case (addr)
          ADDR_ANALOG_INPUT_CONFIG: core_nxt.rd_byte = {core_r.analog, core_r.analog};
          ADDR_DIGITAL_CONTROL_CONFIG: core_nxt.rd_byte = core_r.digital;
          ADDR_FRAME_SYNC_DELAY_COUNT: core_nxt.rd_byte = core_r.fs_delay;
          ADDR_FRAME_SYNC_TOTAL_COUNT: core_nxt.rd_byte = core_r.fs_count;
          default: core_nxt.rd_byte = 8'h00;
        endcase
      end else begin
        case (addr)
          ADDR_ANALOG_INPUT_CONFIG: core_nxt.analog = data[3:0];
          ADDR_DIGITAL_CONTROL_CONFIG: begin
            core_nxt.digital = data & DIG_WRITE_MASK;
            if (data[DIG_SOFT_RESET_BIT]) begin
              // Whole bank back to defaults; reset bit clears with it
              core_nxt.analog = ANALOG_RESET;
              core_nxt.digital = DIGITAL_RESET;
              core_nxt.fs_delay = FS_DELAY_RESET;
              core_nxt.fs_count = FS_COUNT_RESET;
              core_nxt.rd_byte = 8'h00;
              core_nxt.soft_reset = 1'b1;
            end
          end
          ADDR_FRAME_SYNC_DELAY_COUNT: core_nxt.fs_delay = data;
          ADDR_FRAME_SYNC_TOTAL_COUNT: core_nxt.fs_count = data;
          default: core_nxt.rd_byte = core_r.rd_byte;
        endcase
      end
    end
    // Pin governs only while the software bit is clear
    core_nxt.power_down = core_nxt.digital[DIG_SOFT_PDN_BIT] | pdn_pin_core;
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      core_r.analog <= ANALOG_RESET;
      core_r.digital <= DIGITAL_RESET;
      core_r.fs_delay <= FS_DELAY_RESET;
      core_r.fs_count <= FS_COUNT_RESET;
      core_r.rd_byte <= 8'h00;
      core_r.seen_toggle <= 1'b0;
      core_r.soft_reset <= 1'b0;
      core_r.power_down <= 1'b0;
    end else begin
      core_r <= core_nxt;
    end
  end

  assign o_hpf_bypass = core_r.analog[ANA_HPF_BYPASS_BIT];
  assign o_input_sel = input_sel_t'(core_r.analog[ANA_SEL_MSB:ANA_SEL_LSB]);
  assign o_free_run = core_r.digital[DIG_FREE_RUN_BIT];
  assign o_sixteen_bit_mode = core_r.digital[DIG_SIXTEEN_BIT];
  assign o_force_secondary = core_r.digital[DIG_FORCE_SEC_BIT];
  assign o_soft_reset = core_r.soft_reset;
  assign o_power_down = core_r.power_down;

  // Link domain: secondary word shifter and frame-sync generator
  always_comb begin
    link_nxt = link_r;
    link_nxt.fs_pulse = 1'b0;
    link_nxt.fsd_pulse = 1'b0;

    if (i_sec_frame) begin
      link_nxt.bit_cnt = link_r.bit_cnt + 4'h1;
      link_nxt.in_shift = {link_r.in_shift[13:0], i_din};
      if (link_r.bit_cnt == LAST_BIT) begin
        link_nxt.word = {link_r.in_shift, i_din};
        link_nxt.toggle = ~link_r.toggle;
      end
      // Reply holds last read result: upper byte zero
      if (link_r.bit_cnt == 4'h0) begin
        link_nxt.dout = 1'b0;
        link_nxt.out_shift = {8'h00, link_rd_byte} << 1;
      end else begin
        link_nxt.dout = link_r.out_shift[15];
        link_nxt.out_shift = link_r.out_shift << 1;
      end
    end else begin
      link_nxt.bit_cnt = 4'h0;
      link_nxt.dout = 1'b0;
    end

    // Count frame syncs per cycle, spaced evenly
    if (i_frame_start) begin
      link_nxt.fs_left = link_fs_count;
      link_nxt.gap = 8'h00;
    end else if (link_r.fs_left != 8'h00) begin
      if (link_r.gap == 8'h00) begin
        link_nxt.fs_pulse = 1'b1;
        link_nxt.fs_left = link_r.fs_left - 8'h01;
        link_nxt.gap = FS_SPACING - 8'h01;
      end else begin
        link_nxt.gap = link_r.gap - 8'h01;
      end
    end

    // Delayed pulse trails each frame sync while delay is under FS_SPACING; a zero delay never fires
    if (link_nxt.fs_pulse) begin
      link_nxt.dly = link_fs_delay;
    end else if (link_r.dly != 8'h00) begin
      link_nxt.dly = link_r.dly - 8'h01;
      link_nxt.fsd_pulse = (link_r.dly == 8'h01) && !link_fsd_disable;
    end
  end

  always_ff @(posedge i_sclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      link_r <= '0;
    end else begin
      link_r <= link_nxt;
    end
  end

  assign o_dout = link_r.dout;
  assign o_frame_sync_pulse = link_r.fs_pulse;
  assign o_delayed_frame_sync = link_r.fsd_pulse;
endmodule : codec_config_regs_five_to_eight

// ### codec_cfg_sva.sv
`timescale 1ns/1ns
module codec_cfg_sva (
  input wire logic i_clk, i_reset_n, i_sclk, i_sec_frame, i_power_down_pin,
  input wire logic o_dout, o_frame_sync_pulse, o_delayed_frame_sync,
  input wire logic o_hpf_bypass, o_free_run, o_soft_reset, o_power_down,
  input codec_cfg_pkg::input_sel_t o_input_sel
);
  import codec_cfg_pkg::*;
  AST_RST_DEF: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(i_reset_n) |-> o_input_sel == SEL_PRIMARY && !o_hpf_bypass) else $error("reset value");
  AST_SR_PULSE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_soft_reset |=> !o_soft_reset) else $error("soft reset pulse too long");
  AST_SR_DEF: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_soft_reset |-> ##[0:3] (o_input_sel == SEL_PRIMARY && !o_free_run))
    else $error("soft reset kept config");
  AST_PDN_PIN: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_power_down_pin [*5] |-> o_power_down) else $error("pin ignored");
  AST_FS_PULSE: assert property (@(posedge i_sclk) disable iff (!i_reset_n)
    o_frame_sync_pulse |=> !o_frame_sync_pulse [*8]) else $error("frame syncs too close");
  AST_REPLY_HI: assert property (@(posedge i_sclk) disable iff (!i_reset_n)
    $rose(i_sec_frame) |-> !o_dout [*8]) else $error("reply high byte not zero");
  AST_FSD_GAP: assert property (@(posedge i_sclk) disable iff (!i_reset_n)
    o_frame_sync_pulse |=> !o_delayed_frame_sync [*8]) else $error("delayed sync early");
  AST_FSD_PULSE: assert property (@(posedge i_sclk) disable iff (!i_reset_n)
    o_delayed_frame_sync |=> !o_delayed_frame_sync) else $error("delayed sync too long");
  cover property (@(posedge i_clk) o_soft_reset);
  cover property (@(posedge i_sclk) o_delayed_frame_sync);
  cover property (@(posedge i_clk) o_input_sel == SEL_SUMMING);
endmodule : codec_cfg_sva
bind codec_config_regs_five_to_eight codec_cfg_sva codec_cfg_sva_inst (.i_clk, .i_reset_n,
  .i_sclk, .i_sec_frame, .i_power_down_pin, .o_dout, .o_frame_sync_pulse,
  .o_delayed_frame_sync, .o_hpf_bypass, .o_free_run, .o_soft_reset, .o_power_down,
  .o_input_sel);

// ### host_serial_model.sv
`timescale 1ns/1ns
module host_serial_model (
  input wire logic i_sclk,
  input wire logic i_dout,
  output logic o_sec_frame,
  output logic o_din
);
  initial begin
    o_sec_frame = 1'b0;
    o_din = 1'b0;
  end
  // Reply bit k is launched by the edge that takes command bit k
  task automatic send(input logic [15:0] w, output logic [15:0] r);
    @(posedge i_sclk);
    #2;
    o_sec_frame = 1'b1;
    for (int i = 15; i >= 0; i--) begin
      o_din = w[i];
      @(posedge i_sclk);
      #2;
      r = {r[14:0], i_dout};
    end
    o_sec_frame = 1'b0;
    // Released line must not look like the last bit
    o_din = ~o_din;
  endtask : send
endmodule : host_serial_model

// ### tb_codec_config_regs_five_to_eight.sv
`timescale 1ns/1ns
module tb_codec_config_regs_five_to_eight;
  import codec_cfg_pkg::*;
  logic i_clk, i_reset_n, i_sclk, i_sec_frame, i_din, i_frame_start, i_power_down_pin;
  logic o_dout, o_frame_sync_pulse, o_delayed_frame_sync, o_hpf_bypass, o_free_run;
  logic o_sixteen_bit_mode, o_force_secondary, o_soft_reset, o_power_down, sr_seen;
  input_sel_t o_input_sel;
  logic [15:0] rep;
  int err_count = 0;
  int samples_checked = 0;
  int fs_n, fsd_n, gap;
  codec_config_regs_five_to_eight codec_config_regs_five_to_eight_inst (.i_clk, .i_reset_n,
    .i_sclk, .i_sec_frame, .i_din, .i_frame_start, .i_power_down_pin, .o_dout,
    .o_frame_sync_pulse, .o_delayed_frame_sync, .o_hpf_bypass, .o_input_sel, .o_free_run,
    .o_sixteen_bit_mode, .o_force_secondary, .o_soft_reset, .o_power_down);
  host_serial_model host_serial_model_inst (.i_sclk, .i_dout(o_dout),
    .o_sec_frame(i_sec_frame), .o_din(i_din));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial begin
    i_sclk = 1'b0;
    #1;
    forever begin
      i_sclk = ~i_sclk;
      #24;
    end
  end
  always @(negedge i_clk) if (o_soft_reset === 1'b1) sr_seen = 1'b1;
  always @(negedge i_sclk) begin
    gap++;
    if (o_frame_sync_pulse === 1'b1) begin
      fs_n++;
      gap = 0;
    end
    if (o_delayed_frame_sync === 1'b1) begin
      fsd_n++;
      check(16'(gap), 16'd20);
    end
  end
  task check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task wr(input logic [4:0] a, input logic [7:0] d);
    host_serial_model_inst.send({3'b000, a, d}, rep);
    repeat (6) @(posedge i_clk);
  endtask : wr
  task rd(input logic [4:0] a, input logic [7:0] e);
    host_serial_model_inst.send({3'b001, a, 8'h00}, rep);
    // Read byte needs two shift clocks to cross before the next word
    repeat (3) @(posedge i_sclk);
    host_serial_model_inst.send(16'h0000, rep);
    check(rep, {8'h00, e});
  endtask : rd
  task dflt;
    rd(5'h05, 8'h11);
    rd(5'h06, 8'h00);
    rd(5'h07, 8'h00);
    rd(5'h08, 8'h01);
  endtask : dflt
  task burst;
    fs_n = 0;
    fsd_n = 0;
    @(posedge i_sclk) #2 i_frame_start = 1'b1;
    @(posedge i_sclk) #2 i_frame_start = 1'b0;
    repeat (250) @(posedge i_sclk);
  endtask : burst
  task test_done;
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  initial begin
    #500000;
    err_count++;
    test_done;
  end
  initial begin
    {i_reset_n, i_frame_start, i_power_down_pin} = 3'h0;
    repeat (6) @(posedge i_clk);
    #2 i_reset_n = 1'b1;
    check(16'(o_input_sel), 16'(SEL_PRIMARY));
    dflt();
    for (int s = 0; s < 8; s++) begin
      wr(5'h05, 8'ha0 | 8'(s));
      check({o_hpf_bypass, o_input_sel}, 16'(s));
      rd(5'h05, {2{1'b0, s[2:0]}});
    end
    wr(5'h06, 8'hfc);
    check({o_free_run, o_sixteen_bit_mode, o_force_secondary, o_power_down}, 16'he);
    rd(5'h06, 8'h3c);
    wr(5'h06, 8'h01);
    check(o_power_down, 16'h1);
    wr(5'h06, 8'h00);
    #2 i_power_down_pin = 1'b1;
    repeat (6) @(posedge i_clk);
    check(o_power_down, 16'h1);
    #2 i_power_down_pin = 1'b0;
    repeat (6) @(posedge i_clk);
    check(o_power_down, 16'h0);
    wr(5'h09, 8'h55);
    rd(5'h09, 8'h00);
    wr(5'h08, 8'h03);
    wr(5'h07, 8'h14);
    rd(5'h08, 8'h03);
    burst();
    check(16'(fs_n), 16'd3);
    check(16'(fsd_n), 16'd3);
    wr(5'h06, 8'h10);
    burst();
    check(16'(fsd_n), 16'd0);
    check(16'(fs_n), 16'd3);
    sr_seen = 1'b0;
    wr(5'h06, 8'h02);
    check(sr_seen, 16'h1);
    dflt();
    test_done;
  end
endmodule : tb_codec_config_regs_five_to_eight
